// ==== rtl/sram_port_pkg.sv ====
// Constants and carrier types for the burst SRAM synchronous input port
package sram_port_pkg;

  // ----------------------------------------
  // Geometry and reset values
  // ----------------------------------------
  localparam int          ADDR_W     = 19;          // 512K words
  localparam int          LANES      = 2;
  localparam logic [18:0] ADDR_RST   = 19'h00000;
  localparam logic [1:0]  CNT_RST    = 2'h0;
  localparam logic [1:0]  LANE_RST   = 2'h0;
  localparam logic [2:0]  SYNC_RST   = 3'h7;        // Strap idles high (pull-up)
  localparam logic        ILV_RST    = 1'b1;        // Open strap reads as interleaved

  typedef enum logic [1:0] {CYC_IDLE, CYC_READ, CYC_WRITE} cyc_t;

  // Bus inputs sampled every rising clock edge
  typedef struct packed {
    logic        procStrobeN;
    logic        ctrlStrobeN;
    logic        burstAdvanceN;
    logic        byteWriteEnN;
    logic [1:0]  laneSelN;        // [0]=lane A, [1]=lane B
    logic        allBytesWriteN;
    logic        chipSelPipeN;
    logic        chipSelDepthHi;
    logic        chipSelDepthLoN;
    logic [18:0] addr;
  } bus_in_t;

  // Registered state of the port
  typedef struct packed {
    logic [18:0] baseAddr;
    logic [1:0]  burstCnt;
    logic [2:0]  strapSync;
    logic        interleaved;
    logic [1:0]  laneWrite;
    cyc_t        cycle;
  } port_state_t;

  // Scan-side state
  typedef struct packed {
    logic sampledTdi;
    logic sampledTms;
  } scan_state_t;

endpackage

// ==== rtl/sync_burst_sram_input_port.sv ====
// Synchronous address, burst and byte-write capture for the burst SRAM
`timescale 1ns/1ps
module sync_burst_sram_input_port
  import sram_port_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire bus_in_t     busIn,
  input  wire logic        burstOrderStrap,
  input  wire logic        testClk,
  input  wire logic        scanDataIn,
  input  wire logic        scanModeSel,
  output logic [18:0]      wordAddr,
  output logic [1:0]       laneWrite,
  output logic             accessValid,
  output logic             writeCycle,
  output logic             interleavedMode,
  output logic             scanDataOut,
  output logic             scanModeSeen
);

  // ----------------------------------------
  // Burst sequence helper
  // ----------------------------------------
  // Interleaved order XORs the start with the step, linear adds it
  function automatic logic [1:0] burstStep(input logic [1:0] start, input logic [1:0] step,
                                           input logic ilv);
    burstStep = ilv ? (start ^ step) : 2'(start + step);
  endfunction

  // ----------------------------------------
  // Main state
  // ----------------------------------------
  port_state_t st;
  port_state_t next_st;
  logic        chipSelected;
  logic        procTake;
  logic        ctrlTake;

  // Strobe qualification; processor strobe ignored while pipe select is high
  always_comb
  begin
    chipSelected = !busIn.chipSelPipeN && busIn.chipSelDepthHi && !busIn.chipSelDepthLoN;
    procTake     = !busIn.procStrobeN && chipSelected;
    ctrlTake     = busIn.procStrobeN && !busIn.ctrlStrobeN && chipSelected;
  end

  // Next-state logic
  always_comb
  begin
    next_st = st;
    // Strap is static, but synchronise it anyway since it is a pin
    next_st.strapSync = {st.strapSync[1:0], burstOrderStrap};
    if (st.strapSync[2] == st.strapSync[1])
    begin
      next_st.interleaved = st.strapSync[1];
    end
    if (procTake || ctrlTake)
    begin
      next_st.baseAddr = busIn.addr;
      next_st.burstCnt = CNT_RST;
      next_st.cycle    = (!busIn.allBytesWriteN || !busIn.byteWriteEnN) ? CYC_WRITE : CYC_READ;
    end
    else if (!busIn.burstAdvanceN && st.cycle != CYC_IDLE)
    begin
      next_st.burstCnt = 2'(st.burstCnt + 2'h1);
    end
    // Byte lanes: global write wins over lane selects and enable
    if (!busIn.allBytesWriteN)
    begin
      next_st.laneWrite = 2'h3;
    end
    else if (!busIn.byteWriteEnN)
    begin
      next_st.laneWrite = ~busIn.laneSelN;
    end
    else
    begin
      next_st.laneWrite = LANE_RST;
    end
    case (st.cycle)
      CYC_IDLE:  ;
      CYC_READ:  ;
      CYC_WRITE: ;
      default:   next_st.cycle = CYC_IDLE;
    endcase
  end

  // State register
  // Reset follows the pull-up, so order is interleaved until the strap is seen low
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st.baseAddr    <= ADDR_RST;
      st.burstCnt    <= CNT_RST;
      st.strapSync   <= SYNC_RST;
      st.interleaved <= ILV_RST;
      st.laneWrite   <= LANE_RST;
      st.cycle       <= CYC_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Current word: low bits follow the burst sequence from the captured start
  always_comb
  begin
    wordAddr        = {st.baseAddr[18:2],
                       burstStep(st.baseAddr[1:0], st.burstCnt, st.interleaved)};
    laneWrite       = st.laneWrite;
    accessValid     = st.cycle != CYC_IDLE;
    writeCycle      = st.cycle == CYC_WRITE;
    interleavedMode = st.interleaved;
  end

  // ----------------------------------------
  // Boundary-scan pins
  // ----------------------------------------
  // Scan logic runs on its own test clock; only the serial pins are kept here
  scan_state_t sc;
  scan_state_t next_sc;
  logic        outStage;

  // Scan pins captured straight from the pads
  always_comb
  begin
    next_sc.sampledTdi = scanDataIn;
    next_sc.sampledTms = scanModeSel;
  end

  // Inputs taken on the rising test-clock edge
  always_ff @(posedge testClk or negedge nrst)
  begin
    if (!nrst)
    begin
      sc <= '0;
    end
    else
    begin
      sc <= next_sc;
    end
  end

  // Output launched on the falling edge, giving the far end half a period
  always_ff @(negedge testClk or negedge nrst)
  begin
    if (!nrst)
    begin
      outStage <= 1'b0;
    end
    else
    begin
      outStage <= sc.sampledTdi;
    end
  end

  // Serial outputs straight from their registers
  always_comb
  begin
    scanDataOut  = outStage;
    scanModeSeen = sc.sampledTms;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_addr_capture: assert property (@(posedge ref_clk) disable iff (!nrst)
    procTake |=> (st.baseAddr == $past(busIn.addr)) && accessValid)
    else $error("address not captured on qualified strobe");

  chk_ctrl_capture: assert property (@(posedge ref_clk) disable iff (!nrst)
    ctrlTake |=> (st.baseAddr == $past(busIn.addr)) && accessValid)
    else $error("address not captured on controller strobe");

  chk_write_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
    ((procTake || ctrlTake) && !busIn.allBytesWriteN) |=> writeCycle)
    else $error("global write capture not marked as write");

  chk_counter_load: assert property (@(posedge ref_clk) disable iff (!nrst)
    (procTake || ctrlTake) |=> st.burstCnt == 2'h0)
    else $error("burst counter not loaded");

  chk_proc_priority: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!busIn.procStrobeN && !busIn.ctrlStrobeN) |-> !ctrlTake)
    else $error("controller strobe acted beside processor strobe");

  chk_burst_advance: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!procTake && !ctrlTake && !busIn.burstAdvanceN && accessValid)
      |=> st.burstCnt == 2'($past(st.burstCnt) + 2'h1))
    else $error("burst counter did not advance");

  chk_global_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    !busIn.allBytesWriteN |=> laneWrite == 2'h3)
    else $error("global write missed a lane");

  chk_lane_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    (busIn.allBytesWriteN && busIn.byteWriteEnN) |=> laneWrite == 2'h0)
    else $error("lane written without byte-write enable");

  chk_lane_select: assert property (@(posedge ref_clk) disable iff (!nrst)
    (busIn.allBytesWriteN && !busIn.byteWriteEnN) |=> laneWrite == ~$past(busIn.laneSelN))
    else $error("lane write does not follow selects");

  chk_strap_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!burstOrderStrap) [*4] |=> !interleavedMode)
    else $error("strap low did not give linear order");

  chk_scan_out: assert property (@(negedge testClk) disable iff (!nrst)
    1'b1 |=> scanDataOut == $past(sc.sampledTdi))
    else $error("scan output not launched on falling edge");

  chk_scan_in: assert property (@(posedge testClk) disable iff (!nrst)
    1'b1 |=> scanModeSeen == $past(scanModeSel))
    else $error("mode select not sampled on rising edge");

  cov_proc_read: cover property (@(posedge ref_clk) disable iff (!nrst)
    procTake && busIn.allBytesWriteN && busIn.byteWriteEnN);
  cov_ctrl_write: cover property (@(posedge ref_clk) disable iff (!nrst)
    ctrlTake && !busIn.allBytesWriteN);
  cov_full_burst: cover property (@(posedge ref_clk) disable iff (!nrst)
    procTake ##1 (!busIn.burstAdvanceN && !procTake && !ctrlTake) [*3]);
  cov_both_strobes: cover property (@(posedge ref_clk) disable iff (!nrst)
    !busIn.procStrobeN && !busIn.ctrlStrobeN && chipSelected);

endmodule

// ==== dv/bus_master_model.sv ====
// Processor-side bus master that drives the port's synchronous bus
`timescale 1ns/1ps
module bus_master_model
  import sram_port_pkg::*;
(
  input  wire logic ref_clk,
  output bus_in_t   busIn
);
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Strobes off, writes off, chip deselected
  function automatic bus_in_t idle();
    idle = bus_in_t'({4'hf, 2'h3, 1'h1, 1'h1, 1'h0, 1'h1, 19'h00000});
  endfunction

  // All three chip selects active
  function automatic bus_in_t sel(input bus_in_t v);
    sel = v;
    sel.chipSelPipeN = 1'b0;
    sel.chipSelDepthHi = 1'b1;
    sel.chipSelDepthLoN = 1'b0;
  endfunction

  initial busIn = idle();

  // Held a whole cycle so every qualifier is seen at one edge
  task automatic step(input bus_in_t v);
    busIn = v;
    @(posedge ref_clk);
    #1;
  endtask
endmodule

// ==== dv/sync_burst_sram_input_port_tb.sv ====
// Self-checking bench for the burst SRAM input port
`timescale 1ns/1ps
module sync_burst_sram_input_port_tb
  import sram_port_pkg::*;
;
  logic ref_clk, nrst, strap, testClk, scanDataIn, scanModeSel;
  logic [18:0] wordAddr;
  logic [1:0] laneWrite;
  logic accessValid, writeCycle, interleavedMode, scanDataOut, scanModeSeen;
  bus_in_t busIn;
  int err_count = 0;
  int compares = 0;
  // {all-bytes, byte-enable, lane selects, expected lanes}
  localparam logic [5:0] LANE_TAB [5] = '{6'h30, 6'h29, 6'h26, 6'h23, 6'h1f};

  // ----------------------------------------
  // Clock, design and far side
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  bus_master_model bm (.ref_clk(ref_clk), .busIn(busIn));

  sync_burst_sram_input_port uut (.ref_clk(ref_clk), .nrst(nrst), .busIn(busIn),
    .burstOrderStrap(strap), .testClk(testClk), .scanDataIn(scanDataIn),
    .scanModeSel(scanModeSel), .wordAddr(wordAddr), .laneWrite(laneWrite),
    .accessValid(accessValid), .writeCycle(writeCycle), .interleavedMode(interleavedMode),
    .scanDataOut(scanDataOut), .scanModeSeen(scanModeSeen));

  // ----------------------------------------
  // Compare and close
  // ----------------------------------------
  task automatic chk_word(input string n, input logic [18:0] e, input logic [18:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bits(input string n, input logic [1:0] e, input logic [1:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_capture();
    bus_in_t v;
    v = bm.sel(bm.idle());
    v.procStrobeN = 1'b0;
    v.addr = 19'h5a5a6;
    bm.step(v);
    chk_word("wordAddr", 19'h5a5a6, wordAddr);
    chk_bits("valid_write", 2'h2, {accessValid, writeCycle});
    // Deselected chip must not disturb the held address
    v.chipSelDepthHi = 1'b0;
    v.addr = 19'h00003;
    bm.step(v);
    chk_word("wordAddr", 19'h5a5a6, wordAddr);
    v = bm.sel(bm.idle());
    v.procStrobeN = 1'b0;
    v.ctrlStrobeN = 1'b0;
    v.allBytesWriteN = 1'b0;
    v.addr = 19'h2c3d8;
    bm.step(v);
    chk_word("wordAddr", 19'h2c3d8, wordAddr);
    chk_bits("valid_write", 2'h3, {accessValid, writeCycle});
    // Controller strobe alone must capture as well
    v.procStrobeN = 1'b1;
    v.allBytesWriteN = 1'b1;
    v.addr = 19'h0777e;
    bm.step(v);
    chk_word("wordAddr", 19'h0777e, wordAddr);
    chk_bits("valid_write", 2'h2, {accessValid, writeCycle});
    $display("capture test done");
  endtask

  task automatic t_lanes();
    bus_in_t v;
    for (int i = 0; i < 5; i++)
    begin
      v = bm.idle();
      v.allBytesWriteN = LANE_TAB[i][5];
      v.byteWriteEnN = LANE_TAB[i][4];
      v.laneSelN = LANE_TAB[i][3:2];
      bm.step(v);
      chk_bits("laneWrite", LANE_TAB[i][1:0], laneWrite);
    end
    $display("lane test done");
  endtask

  // Seq holds the low bits after advance steps one to three
  task automatic t_burst(input logic s, input logic [7:0] seq);
    bus_in_t v;
    // Strap moves only while the port is held in reset
    nrst = 1'b0;
    strap = s;
    repeat (2) bm.step(bm.idle());
    chk_bits("valid_write", 2'h0, {accessValid, writeCycle});
    nrst = 1'b1;
    repeat (6) bm.step(bm.idle());
    chk_bits("interleavedMode", {1'b0, s}, {1'b0, interleavedMode});
    v = bm.sel(bm.idle());
    v.procStrobeN = 1'b0;
    v.addr = 19'h12341;
    bm.step(v);
    chk_word("wordAddr", 19'h12341, wordAddr);
    v = bm.idle();
    v.burstAdvanceN = 1'b0;
    for (int i = 1; i < 4; i++)
    begin
      bm.step(v);
      chk_word("wordAddr", 19'h12340 | {17'h0, seq[2*i +: 2]}, wordAddr);
    end
    $display("burst test done, strap %b", s);
  endtask

  // Scan clock only moves here and stands still otherwise
  task automatic t_scan();
    scanDataIn = 1'b1;
    scanModeSel = 1'b1;
    #10 testClk = 1'b1;
    #1 chk_bits("scanModeSeen", 2'h1, {1'b0, scanModeSeen});
    chk_bits("scanDataOut", 2'h0, {1'b0, scanDataOut});
    #10 testClk = 1'b0;
    #1 chk_bits("scanDataOut", 2'h1, {1'b0, scanDataOut});
    scanDataIn = 1'b0;
    scanModeSel = 1'b0;
    #10 testClk = 1'b1;
    #1 chk_bits("scanModeSeen", 2'h0, {1'b0, scanModeSeen});
    chk_bits("scanDataOut", 2'h1, {1'b0, scanDataOut});
    #10 testClk = 1'b0;
    #1 chk_bits("scanDataOut", 2'h0, {1'b0, scanDataOut});
    $display("scan test done");
  endtask

  initial
  begin
    nrst = 1'b0;
    strap = 1'b1;
    testClk = 1'b0;
    scanDataIn = 1'b0;
    scanModeSel = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 nrst = 1'b1;
    t_capture();
    t_lanes();
    t_burst(1'b1, 8'hb1);
    t_burst(1'b0, 8'h39);
    t_scan();
    close_out();
  end

  // Run needs about 1.3 us; cut a hang well past that
  initial
  begin
    #20000;
    err_count++;
    close_out();
  end
endmodule
